/* design/sac_top.sv */
`timescale 1ns/1ns
// Function
// - Interrupts off: done flag sets each conversion end, clears on result read or reset.
// - Interrupts on: done flag never sets and reads as zero.
// - Interrupts on: interrupt request raised at each conversion end.
// - Interrupt request drops on result read or status/control write.
// - Continuous mode converts repeatedly, updating the result each time.
// - Single mode performs exactly one conversion per start.
// - Reset clears enables and sets all channel select bits to one.
// - Select codes 0 to 3 route the four analog input pins.
// - Codes 11101 and 11110 route internal high and low references.
// - All-ones select code powers the converter off.
// - Unused or reserved codes give an undefined result.
// - Result is one read-only byte updated at each completion.
// - Three-bit prescale divides bus clock by 1, 2, 4, 8 or 16.
// - A conversion with sampling spans at most 16 converter clocks.
// - One conversion takes sixteen converter clocks after a start, fifteen when repeated in continuous mode.
// - Conversion begins on first converter clock after a control write.
// - Selected pin is forced to analog input, port writes ignored.
module sac_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic              comp_i,
    output logic      [7:0]        rd_data_o,
    output logic                   irq_o,
    output logic      [3:0]        pin_analog_o,
    output logic                   high_ref_sel_o,
    output logic                   low_ref_sel_o,
    output logic                   power_o,
    output logic                   sample_o,
    output logic      [7:0]        dac_code_o
);

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    generate
        if (ADDR_W < 6) begin : g_bad_addr
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    sac_clk_if clk_if ();

    logic                 irq_en_reg;
    logic                 cont_reg;
    logic [4:0]           input_select_reg;
    logic [2:0]           prescale_ratio_reg;
    logic                 done_flag_reg;
    logic                 irq_reg;
    logic [7:0]           result_reg;
    logic [7:0]           trial_reg;
    logic [3:0]           tick_cnt_reg;
    logic                 sample_reg;
    logic [7:0]           rd_data_reg;
    logic [3:0]           pin_analog_reg;
    logic                 high_ref_reg;
    logic                 low_ref_reg;
    logic                 power_reg;
    logic                 comp_meta_reg;
    logic                 comp_sync_reg;
    sac_pkg::sac_state_t  state_reg;
    logic                 sel_wr;
    logic                 sel_rd_result;
    logic                 sel_rd_sc;
    logic                 sel_rd_pre;
    logic                 sel_wr_pre;
    logic                 conv_done;
    logic                 powered;
    logic [7:0]           bit_mask;
    logic [7:0]           decided;
    logic [3:0]           pin_route_sel;

    // ---------------------------------------------------------------
    // Address decode helper
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Channel code to one-hot pin route, zero for non-pin codes
    function automatic logic [3:0] pin_route(input logic [4:0] code);
        logic [3:0] v;
        v = 4'h0;
        if (code < 5'(sac_pkg::PIN_INPUTS)) begin
            v = 4'h1 << code[1:0];
        end
        return v;
    endfunction

    assign sel_wr        = wr_i && hit(addr_i, sac_pkg::STATUS_CONTROL_OFS);
    assign sel_wr_pre    = wr_i && hit(addr_i, sac_pkg::PRESCALE_OFS);
    assign sel_rd_result = rd_i && hit(addr_i, sac_pkg::RESULT_OFS);
    assign sel_rd_sc     = rd_i && hit(addr_i, sac_pkg::STATUS_CONTROL_OFS);
    assign sel_rd_pre    = rd_i && hit(addr_i, sac_pkg::PRESCALE_OFS);
    assign powered       = input_select_reg != sac_pkg::SEL_POWER_OFF;

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    assign clk_if.ratio   = prescale_ratio_reg;
    assign clk_if.restart = sel_wr;

    sac_prescaler u_prescaler (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clk_if (clk_if)
    );

    // ---------------------------------------------------------------
    // Comparator synchroniser
    // ---------------------------------------------------------------
    // Two stages before the comparator result is used
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= comp_i;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    // Status/control write; done flag position is ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_reg       <= 1'b0;
            cont_reg         <= 1'b0;
            input_select_reg <= sac_pkg::SEL_RESET;
        end else if (sel_wr) begin
            irq_en_reg       <= wr_data_i[sac_pkg::IRQ_EN_BIT];
            cont_reg         <= wr_data_i[sac_pkg::CONT_BIT];
            input_select_reg <= wr_data_i[sac_pkg::SEL_LSB +: sac_pkg::SEL_W];
        end
    end

    // Prescale ratio register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale_ratio_reg <= sac_pkg::RATIO_RESET;
        end else if (sel_wr_pre) begin
            prescale_ratio_reg <= wr_data_i[sac_pkg::RATIO_LSB +: sac_pkg::RATIO_W];
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    // Bit under decision and the trial with it resolved
    always_comb begin
        bit_mask = sac_pkg::TRIAL_FIRST >> (tick_cnt_reg - sac_pkg::SAMPLE_LAST - sac_pkg::FIRST_TICK);
        decided  = comp_sync_reg ? trial_reg : (trial_reg & ~bit_mask);
    end

    assign conv_done = (state_reg == sac_pkg::SAC_CONV) && clk_if.tick
                       && (tick_cnt_reg == sac_pkg::CONV_TICKS_LAST);

    // State, tick count and sample window
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg    <= sac_pkg::SAC_IDLE;
            tick_cnt_reg <= 4'h0;
            sample_reg   <= 1'b0;
        end else if (sel_wr) begin
            // Any control write aborts; it rearms unless the select code is all ones
            tick_cnt_reg <= 4'h0;
            sample_reg   <= 1'b0;
            if (wr_data_i[sac_pkg::SEL_LSB +: sac_pkg::SEL_W] == sac_pkg::SEL_POWER_OFF) begin
                state_reg <= sac_pkg::SAC_IDLE;
            end else begin
                state_reg <= sac_pkg::SAC_ARM;
            end
        end else begin
            case (state_reg)
                sac_pkg::SAC_IDLE: begin
                    tick_cnt_reg <= 4'h0;
                    sample_reg   <= 1'b0;
                end
                sac_pkg::SAC_ARM: begin
                    if (clk_if.tick) begin
                        state_reg    <= sac_pkg::SAC_CONV;
                        tick_cnt_reg <= sac_pkg::FIRST_TICK;
                        sample_reg   <= 1'b1;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (conv_done) begin
                        if (cont_reg) begin
                            tick_cnt_reg <= sac_pkg::FIRST_TICK;
                            sample_reg   <= 1'b1;
                        end else begin
                            state_reg    <= sac_pkg::SAC_IDLE;
                            tick_cnt_reg <= 4'h0;
                        end
                    end else if (clk_if.tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                        if (tick_cnt_reg == sac_pkg::SAMPLE_LAST) begin
                            sample_reg <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // Successive approximation trial value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trial_reg <= 8'h00;
        end else if (state_reg == sac_pkg::SAC_CONV && clk_if.tick && !sel_wr) begin
            if (tick_cnt_reg == sac_pkg::SAMPLE_LAST) begin
                trial_reg <= sac_pkg::TRIAL_FIRST;
            end else if (tick_cnt_reg > sac_pkg::SAMPLE_LAST && !conv_done) begin
                trial_reg <= decided | (bit_mask >> 1);
            end
        end
    end

    // Result byte, undefined codes simply convert what the mux gives
    always_ff @(posedge clk_i) begin
        if (conv_done && !sel_wr) begin
            result_reg <= decided;
        end
    end

    // ---------------------------------------------------------------
    // Completion flag and interrupt
    // ---------------------------------------------------------------
    // Flag only in polled mode; completion wins over a result read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_flag_reg <= 1'b0;
        end else if (conv_done && !sel_wr && !irq_en_reg) begin
            done_flag_reg <= 1'b1;
        end else if (sel_rd_result) begin
            done_flag_reg <= 1'b0;
        end
    end

    // Interrupt request; completion wins over a result read, a control write wins over completion
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else if (conv_done && !sel_wr && irq_en_reg) begin
            irq_reg <= 1'b1;
        end else if (sel_rd_result || sel_wr) begin
            irq_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= 8'h00;
        end else if (sel_rd_sc) begin
            rd_data_reg <= {done_flag_reg & ~irq_en_reg,
                            irq_en_reg, cont_reg, input_select_reg};
        end else if (sel_rd_result) begin
            rd_data_reg <= result_reg;
        end else if (sel_rd_pre) begin
            rd_data_reg <= {prescale_ratio_reg, 5'h00};
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Analog routing
    // ---------------------------------------------------------------
    // Per-pin analog override of the port logic
    assign pin_route_sel = pin_route(input_select_reg);
    generate
        for (genvar i = 0; i < sac_pkg::PIN_INPUTS; i++) begin : g_pin
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    pin_analog_reg[i] <= 1'b0;
                end else begin
                    pin_analog_reg[i] <= pin_route_sel[i];
                end
            end
        end
    endgenerate

    // Reference routing and converter power
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_ref_reg <= 1'b0;
            low_ref_reg  <= 1'b0;
            power_reg    <= 1'b0;
        end else begin
            high_ref_reg <= input_select_reg == sac_pkg::SEL_HIGH_REF;
            low_ref_reg  <= input_select_reg == sac_pkg::SEL_LOW_REF;
            power_reg    <= powered;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rd_data_o      = rd_data_reg;
    assign irq_o          = irq_reg;
    assign pin_analog_o   = pin_analog_reg;
    assign high_ref_sel_o = high_ref_reg;
    assign low_ref_sel_o  = low_ref_reg;
    assign power_o        = power_reg;
    assign sample_o       = sample_reg;
    assign dac_code_o     = trial_reg;

endmodule

/* design/sac_pkg.sv */
package sac_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] STATUS_CONTROL_OFS = 8'h3c;
    localparam logic [7:0] RESULT_OFS         = 8'h3e;
    localparam logic [7:0] PRESCALE_OFS       = 8'h3f;

    // ---------------------------------------------------------------
    // Status/control fields
    // ---------------------------------------------------------------
    localparam int DONE_BIT    = 7;
    localparam int IRQ_EN_BIT  = 6;
    localparam int CONT_BIT    = 5;
    localparam int SEL_LSB     = 0;
    localparam int SEL_W       = 5;

    localparam logic [4:0] SEL_RESET     = 5'h1f;
    localparam logic [4:0] SEL_POWER_OFF = 5'h1f;
    localparam logic [4:0] SEL_HIGH_REF  = 5'h1d;
    localparam logic [4:0] SEL_LOW_REF   = 5'h1e;
    localparam int         PIN_INPUTS    = 4;

    // ---------------------------------------------------------------
    // Prescale fields and ratios
    // ---------------------------------------------------------------
    localparam int         RATIO_LSB   = 5;
    localparam int         RATIO_W     = 3;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam int         DIV_W       = 5;

    // ---------------------------------------------------------------
    // Conversion timing in converter clocks
    // ---------------------------------------------------------------
    localparam logic [3:0] CONV_TICKS_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_LAST     = 4'h7;
    localparam logic [3:0] FIRST_TICK      = 4'h1;
    localparam logic [7:0] TRIAL_FIRST     = 8'h80;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_ARM  = 2'b01,
        SAC_CONV = 2'b10
    } sac_state_t;

endpackage

/* design/sac_clk_if.sv */
`timescale 1ns/1ns
// Converter clock request and tick between sequencer and prescaler
interface sac_clk_if;
    logic [2:0] ratio;
    logic       restart;
    logic       tick;

    modport ctrl (output ratio, output restart, input tick);
    modport div  (input ratio, input restart, output tick);
endinterface

/* design/sac_prescaler.sv */
`timescale 1ns/1ns
module sac_prescaler (
    input  wire logic clk_i,
    input  wire logic rst_i,
    sac_clk_if.div    clk_if
);

    logic [sac_pkg::DIV_W-1:0] count_reg;
    logic [sac_pkg::DIV_W-1:0] last_count;
    logic                      tick_now;

    // ---------------------------------------------------------------
    // Ratio decode
    // ---------------------------------------------------------------
    function automatic logic [sac_pkg::DIV_W-1:0] last_of(input logic [2:0] r);
        logic [sac_pkg::DIV_W-1:0] v;
        v = 5'h00;
        case (r)
            3'h0: v = 5'h00;                   // Divide by 1
            3'h1: v = 5'h01;                   // Divide by 2
            3'h2: v = 5'h03;                   // Divide by 4
            3'h3: v = 5'h07;                   // Divide by 8
            default: v = 5'h0f;                // Top bit set: by 16
        endcase
        return v;
    endfunction

    assign last_count = last_of(clk_if.ratio);

    // Tick in the bus cycle that closes a converter period, no extra lag
    assign tick_now = count_reg >= last_count;

    // Bus clock divider, phase restarted on control writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 5'h00;
        end else if (clk_if.restart) begin
            count_reg <= 5'h00;
        end else if (tick_now) begin
            count_reg <= 5'h00;
        end else begin
            count_reg <= count_reg + 5'h01;
        end
    end

    assign clk_if.tick = tick_now;

endmodule

/* dv/sac_top_properties.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module sac_top_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wr_data_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic              comp_i,
    input wire logic [7:0]        rd_data_o,
    input wire logic              irq_o,
    input wire logic [3:0]        pin_analog_o,
    input wire logic              high_ref_sel_o,
    input wire logic              low_ref_sel_o,
    input wire logic              power_o,
    input wire logic              sample_o,
    input wire logic [7:0]        dac_code_o
);
    logic [2:0] ratio_reg;
    logic [6:0] ctl_reg;
    int         cnt_reg;
    int         div;
    logic       rd_st;
    logic       rd_pre;
    logic       rd_res;
    logic       rd_bad;
    logic [5:0] route;

    // Decoded accesses
    assign rd_st  = rd_i && addr_i == sac_pkg::STATUS_CONTROL_OFS;
    assign rd_pre = rd_i && addr_i == sac_pkg::PRESCALE_OFS;
    assign rd_res = rd_i && addr_i == sac_pkg::RESULT_OFS;
    assign rd_bad = rd_i && !rd_st && !rd_pre && !rd_res;
    assign route  = {pin_analog_o, high_ref_sel_o, low_ref_sel_o};
    assign div    = ratio_reg[2] ? 16 : (1 << ratio_reg);

    // Shadow of written fields and cycles since last control write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ratio_reg <= 3'h0;
            ctl_reg   <= 7'h1f;
            cnt_reg   <= 0;
        end else begin
            cnt_reg <= cnt_reg + 1;
            if (wr_i && addr_i == sac_pkg::PRESCALE_OFS) begin
                ratio_reg <= wr_data_i[7:5];
            end
            if (wr_i && addr_i == sac_pkg::STATUS_CONTROL_OFS) begin
                ctl_reg <= wr_data_i[6:0];
                cnt_reg <= 0;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_status_wr;
        wr_i && addr_i == sac_pkg::STATUS_CONTROL_OFS;
    endsequence
    sequence s_result_rd;
        rd_res;
    endsequence

    a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 8'h00) else $error("read data not idle");
    a_unmapped_rd: assert property ($past(rd_bad) |-> rd_data_o == 8'h00) else $error("unmapped read not zero");
    a_status_read: assert property ($past(rd_st) |-> rd_data_o[6:0] == $past(ctl_reg)) else $error("status fields");
    a_flag_masked: assert property ($past(rd_st) && ctl_reg[6] |-> !rd_data_o[7]) else $error("flag seen");
    a_ratio_read: assert property ($past(rd_pre) |-> rd_data_o == {$past(ratio_reg), 5'h00}) else $error("ratio");
    a_irq_needs_en: assert property ($rose(irq_o) |-> ctl_reg[6]) else $error("irq while disabled");
    a_conv_length: assert property ($rose(irq_o) |-> cnt_reg != 0 && cnt_reg % (16 * div) == 0)
        else $error("conversion length wrong");
    a_irq_clr_rd: assert property (s_result_rd |=> !irq_o) else $error("irq kept after result read");
    a_irq_clr_wr: assert property (s_status_wr |=> !irq_o) else $error("irq kept after control write");
    a_route_off: assert property (!power_o |-> route == 6'h00) else $error("routed while off");
    a_route_onehot: assert property ($onehot0(route)) else $error("several inputs routed");
    a_sample_power: assert property (sample_o |-> power_o) else $error("sampling while off");
    a_dac_msb: assert property ($fell(sample_o) && !$past(wr_i) && !$past(wr_i, 2) |-> dac_code_o == 8'h80)
        else $error("first trial not msb");
endmodule

bind sac_top sac_top_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .comp_i(comp_i), .rd_data_o(rd_data_o), .irq_o(irq_o), .pin_analog_o(pin_analog_o),
    .high_ref_sel_o(high_ref_sel_o), .low_ref_sel_o(low_ref_sel_o), .power_o(power_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o)
);

/* dv/sac_afe_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Analog mux and comparator model
// ----------------------------------------
module sac_afe_model (
    input  wire logic            clk_i,
    input  wire logic [3:0][7:0] level_i,
    input  wire logic [3:0]      pin_i,
    input  wire logic            hi_i,
    input  wire logic            lo_i,
    input  wire logic [7:0]      dac_i,
    output logic                 comp_o
);
    logic       noise_reg = 1'b0;
    logic [7:0] vin;
    logic       routed;

    // Changing pattern while nothing is routed
    always_ff @(posedge clk_i) noise_reg <= !noise_reg;

    // Input mux then comparator
    always_comb begin
        vin    = 8'h00;
        routed = hi_i | lo_i | (|pin_i);
        for (int k = 0; k < 4; k++) if (pin_i[k]) vin = level_i[k];
        if (hi_i) vin = 8'hff;
        comp_o = routed ? (vin >= dac_i) : noise_reg;
    end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb_top;
    typedef struct packed {logic [7:0] ctl; logic [7:0] res; logic [5:0] route;} sac_row_t;
    localparam logic [7:0] ST = sac_pkg::STATUS_CONTROL_OFS;
    localparam logic [7:0] RS = sac_pkg::RESULT_OFS;
    localparam logic [7:0] PS = sac_pkg::PRESCALE_OFS;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic [7:0]      addr_i = 8'h00;
    logic [7:0]      wr_data_i = 8'h00;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic            comp_i;
    logic [7:0]      rd_data_o, dac_code_o, d;
    logic            irq_o, high_ref_sel_o, low_ref_sel_o, power_o, sample_o;
    logic [3:0]      pin_analog_o;
    logic [3:0][7:0] levels = {8'h7e, 8'h81, 8'hc5, 8'h3a};
    int              num_errors = 0, n_checks = 0, cyc = 0, n;
    sac_row_t        rows [6] = '{'{8'h00, 8'h3a, 6'h04}, '{8'h01, 8'hc5, 6'h08}, '{8'h02, 8'h81, 6'h10},
                                  '{8'h03, 8'h7e, 6'h20}, '{8'h1d, 8'hff, 6'h02}, '{8'h1e, 8'h00, 6'h01}};

    // Clock, design and far side
    always #5 clk_i = ~clk_i;
    sac_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
        .rd_i(rd_i), .comp_i(comp_i), .rd_data_o(rd_data_o), .irq_o(irq_o), .pin_analog_o(pin_analog_o),
        .high_ref_sel_o(high_ref_sel_o), .low_ref_sel_o(low_ref_sel_o), .power_o(power_o),
        .sample_o(sample_o), .dac_code_o(dac_code_o));
    sac_afe_model afe (.clk_i(clk_i), .level_i(levels), .pin_i(pin_analog_o), .hi_i(high_ref_sel_o),
        .lo_i(low_ref_sel_o), .dac_i(dac_code_o), .comp_o(comp_i));

    // Bus cycles, waits and comparison
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
    endtask
    task automatic wc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ST, d);
        chk(d, 8'h1f);
        rd(PS, d);
        chk(d, 8'h00);
        chk(power_o, 1'b0);
        wr(PS, 8'h40);
        wr(ST, 8'h00);
        wc(70);
        rd(RS, d);
        for (int i = 0; i < 6; i++) begin
            wr(ST, rows[i].ctl);
            wc(2);
            chk(rows[i].route, {pin_analog_o, high_ref_sel_o, low_ref_sel_o});
            wc(63);
            rd(ST, d);
            chk(d, {1'b1, rows[i].ctl[6:0]});
            rd(RS, d);
            chk(d, rows[i].res);
            rd(ST, d);
            chk(d, rows[i].ctl);
        end
        wr(ST, 8'h41);
        wc(65);
        chk(irq_o, 1'b1);
        rd(ST, d);
        chk(d, 8'h41);
        wr(ST, 8'h41);
        wc(1);
        chk(irq_o, 1'b0);
        wc(64);
        chk(irq_o, 1'b1);
        rd(RS, d);
        chk({d, 7'h00, irq_o}, {8'hc5, 8'h00});
        for (int r = 0; r < 8; r++) begin
            wr(PS, {r[2:0], 5'h1f});
            rd(PS, d);
            chk(d, {r[2:0], 5'h00});
            wr(ST, 8'h40);
            n = 0;
            do begin
                @(posedge clk_i);
                #1 n++;
            end while (irq_o !== 1'b1 && n < 300);
            chk(n[15:0], (r > 3) ? 16'd256 : 16'd16 << r);
        end
        wr(PS, 8'h40);
        levels[0] <= 8'h20;
        wr(ST, 8'h20);
        wc(130);
        rd(RS, d);
        chk(d, 8'h20);
        levels[0] <= 8'h90;
        wc(130);
        rd(ST, d);
        chk(d, 8'ha0);
        rd(RS, d);
        chk(d, 8'h90);
        wr(ST, 8'h00);
        wc(65);
        rd(RS, d);
        wc(80);
        rd(ST, d);
        chk({d, 7'h00, sample_o}, 16'h0000);
        wc(30);
        wr(ST, 8'h03);
        wc(40);
        rd(ST, d);
        chk(d, 8'h03);
        wc(30);
        rd(ST, d);
        chk(d, 8'h83);
        rd(8'h3d, d);
        chk(d, 8'h00);
        wr(RS, 8'h55);
        rd(RS, d);
        chk(d, 8'h7e);
        wr(ST, 8'h1f);
        wc(2);
        chk({power_o, pin_analog_o, high_ref_sel_o, low_ref_sel_o}, 7'h00);
        finish_test();
    end
endmodule
